//--- bench/dqvr_ctrl_model.sv
// controller model issuing mode register commands on the link clock
`timescale 1ns/1ns
module dqvr_ctrl_model (
   // link clock
   input  wire logic           CMD_CLK,
   // command toward the device
   output dqvr_pkg::dqvr_cmd_t CMD
);
   import dqvr_pkg::*;
   initial CMD = '0;
   // one command, then a released bus showing inverted leftovers, never stale values
   task automatic issue(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge CMD_CLK);
      #1;
      CMD = '{wr: w, rd: !w, addr: a, op: d};
      @(posedge CMD_CLK);
      #1;
      CMD = '{wr: 1'b0, rd: 1'b0, addr: ~a, op: ~d};
   endtask
endmodule

//--- bench/dqvr_mode_reg_sva.sv
// assertions on the ports of the dq reference mode register
`timescale 1ns/1ns
`include "dqvr_defs.svh"
module dqvr_mode_reg_sva (
   // clocks and reset
   input wire logic                  CORE_CLK,
   input wire logic                  RST,
   input wire logic                  CMD_CLK,
   // command link and data lines
   input wire dqvr_pkg::dqvr_cmd_t   CMD,
   input wire logic [7:0]            DQ_OUT,
   input wire logic                  DQ_OE,
   // core view
   input wire dqvr_pkg::dqvr_level_t ACTIVE_LEVEL,
   input wire logic                  ACTIVE_SET_POINT,
   input wire logic [9:0]            ACTIVE_VREF_TENTHS
);
   import dqvr_pkg::*;
   wire       rd_lvl = CMD.rd && !CMD.wr && CMD.addr == `DQVR_ADDR_LEVEL;
   wire       wr_ok  = CMD.wr && CMD.addr == `DQVR_ADDR_LEVEL && CMD.op[5:0] <= `DQVR_CODE_MAX;
   wire [6:0] op_lo  = CMD.op[6:0];
   // an idle cycle in between keeps a select change out of the window
   sequence wr_then_rd;
      wr_ok ##1 !CMD.wr ##1 rd_lvl;
   endsequence
   read_answer_a: assert property (@(posedge CMD_CLK) disable iff (RST) rd_lvl |=> DQ_OE)
      else $error("no data after level read");
   oe_cause_a: assert property (@(posedge CMD_CLK) disable iff (RST) DQ_OE |-> $past(rd_lvl))
      else $error("data driven without level read");
   idle_zero_a: assert property (@(posedge CMD_CLK) disable iff (RST) !DQ_OE |-> DQ_OUT == 8'h00)
      else $error("data lines not zero when idle");
   reserved_zero_a: assert property (@(posedge CMD_CLK) disable iff (RST) DQ_OE |-> !DQ_OUT[7])
      else $error("reserved bit read as one");
   write_readback_a: assert property (@(posedge CMD_CLK) disable iff (RST)
      wr_then_rd |=> DQ_OUT == {1'b0, $past(op_lo, 3)})
      else $error("read does not return written value");
   write_wins_a: assert property (@(posedge CMD_CLK) disable iff (RST) CMD.wr |=> !DQ_OE)
      else $error("write produced read data");
   vref_map_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      ACTIVE_VREF_TENTHS == (ACTIVE_LEVEL.range_sel ? `DQVR_BASE_RANGE1 : `DQVR_BASE_RANGE0)
      + 10'(ACTIVE_LEVEL.setting) * 10'h006) else $error("reference level off its code");
   core_reset_a: assert property (@(posedge CORE_CLK) disable iff (RST) $fell(RST) |->
      !ACTIVE_SET_POINT && ACTIVE_LEVEL == 7'h40) else $error("core view not at defaults");
endmodule

bind dqvr_mode_reg dqvr_mode_reg_sva u_dqvr_mode_reg_sva (.CORE_CLK(CORE_CLK), .RST(RST),
   .CMD_CLK(CMD_CLK), .CMD(CMD), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ACTIVE_LEVEL(ACTIVE_LEVEL),
   .ACTIVE_SET_POINT(ACTIVE_SET_POINT), .ACTIVE_VREF_TENTHS(ACTIVE_VREF_TENTHS));

//--- bench/tb.sv
// testbench: level writes and reads, set-point switching and the core view
`timescale 1ns/1ns
module tb;
   import dqvr_pkg::*;
   logic        core_clk = 1'b0;
   logic        cmd_clk  = 1'b0;
   logic        rst      = 1'b1;
   dqvr_cmd_t   cmd;
   logic [7:0]  dq_out;
   logic        dq_oe;
   dqvr_level_t act_level;
   logic        act_sp;
   logic [9:0]  act_vref;
   int          fails    = 0;
   int          n_tests  = 0;

   dqvr_mode_reg u_dqvr_mode_reg (.CORE_CLK(core_clk), .RST(rst), .CMD_CLK(cmd_clk),
      .CMD(cmd), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .ACTIVE_LEVEL(act_level),
      .ACTIVE_SET_POINT(act_sp), .ACTIVE_VREF_TENTHS(act_vref));
   dqvr_ctrl_model u_dqvr_ctrl_model (.CMD_CLK(cmd_clk), .CMD(cmd));

   initial begin
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #7;
      forever #3 cmd_clk = ~cmd_clk;
   end

   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic rd(input logic [5:0] a, input logic oe, input logic [7:0] d);
      u_dqvr_ctrl_model.issue(1'b0, a, 8'h00);
      chk("dq_oe", {9'h000, dq_oe}, {9'h000, oe});
      chk("dq_out", {2'h0, dq_out}, {2'h0, d});
   endtask
   // the crossing has no done flag, so poll the level under a bound
   task automatic wait_core(input logic [6:0] lvl);
      int i;
      for (i = 0; i < 40 && act_level !== lvl; i++) begin
         @(posedge core_clk);
         #1;
      end
      if (act_level !== lvl) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic do_reset();
      rst = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge cmd_clk);
   endtask

   initial begin
      do_reset();
      chk("level", {3'h0, act_level}, 10'h040);
      chk("set_point", {9'h000, act_sp}, 10'h000);
      chk("vref", act_vref, 10'h149);
      rd(6'h0e, 1'b1, 8'h40);
      u_dqvr_ctrl_model.issue(1'b1, 6'h0e, 8'hb2);
      rd(6'h0e, 1'b1, 8'h32);
      u_dqvr_ctrl_model.issue(1'b1, 6'h0e, 8'h73);
      rd(6'h0e, 1'b1, 8'h32);
      wait_core(7'h32);
      chk("vref", act_vref, 10'h1c2);
      u_dqvr_ctrl_model.issue(1'b1, 6'h0d, 8'h40);
      u_dqvr_ctrl_model.issue(1'b1, 6'h0e, 8'h45);
      rd(6'h0e, 1'b1, 8'h45);
      repeat (10) @(posedge core_clk);
      chk("level", {3'h0, act_level}, 10'h032);
      u_dqvr_ctrl_model.issue(1'b1, 6'h0d, 8'h00);
      rd(6'h0e, 1'b1, 8'h32);
      rd(6'h0d, 1'b0, 8'h00);
      u_dqvr_ctrl_model.issue(1'b1, 6'h0d, 8'h80);
      wait_core(7'h45);
      chk("set_point", {9'h000, act_sp}, 10'h001);
      chk("vref", act_vref, 10'h167);
      do_reset();
      chk("set_point", {9'h000, act_sp}, 10'h000);
      rd(6'h0e, 1'b1, 8'h40);
      stop_test();
   end
endmodule

//--- design/dqvr_mode_reg.sv
// dq reference-level mode register with two set-point copies and a core-side view
`timescale 1ns/1ns
`include "dqvr_defs.svh"

module dqvr_mode_reg (
   // core clock domain
   input  wire logic                  CORE_CLK,
   input  wire logic                  RST,
   // command link, on its own clock
   input  wire logic                  CMD_CLK,
   input  wire dqvr_pkg::dqvr_cmd_t   CMD,
   // data lines toward the controller
   output logic [7:0]                 DQ_OUT,
   output logic                       DQ_OE,
   // active reference level, core domain
   output dqvr_pkg::dqvr_level_t      ACTIVE_LEVEL,
   output logic                       ACTIVE_SET_POINT,
   output logic [9:0]                 ACTIVE_VREF_TENTHS
);
   import dqvr_pkg::*;

   // ---------------- link domain ----------------

   // reset release synchronised to the link clock
   logic                lrst_meta_reg;
   logic                lrst_reg;

   always_ff @(posedge CMD_CLK or posedge RST) begin
      if (RST) begin
         lrst_meta_reg <= 1'h1;
         lrst_reg      <= 1'h1;
      end else begin
         lrst_meta_reg <= 1'h0;
         lrst_reg      <= lrst_meta_reg;
      end
   end

   // command decode
   wire                 hit_level;
   wire                 hit_spctl;
   wire                 code_ok;
   wire                 level_wr;
   wire                 spctl_wr;
   wire                 level_rd;
   dqvr_level_t         wr_level;

   assign hit_level = (CMD.addr == `DQVR_ADDR_LEVEL);
   assign hit_spctl = (CMD.addr == `DQVR_ADDR_SPCTL);
   // a reserved code is dropped whole so the copy never holds an illegal level
   assign code_ok   = (CMD.op[`DQVR_SETTING_MSB:`DQVR_SETTING_LSB] <= `DQVR_CODE_MAX);
   assign level_wr  = CMD.wr & hit_level & code_ok;
   assign spctl_wr  = CMD.wr & hit_spctl;
   // a write on the same edge wins over a read
   assign level_rd  = CMD.rd & ~CMD.wr & hit_level;

   // setting and range always land together from one operand byte
   assign wr_level.range_sel = CMD.op[`DQVR_RANGE_BIT];
   assign wr_level.setting   = CMD.op[`DQVR_SETTING_MSB:`DQVR_SETTING_LSB];

   // set-point selects; only these two bits of the control register live here
   logic                wr_sel_reg;
   logic                op_sel_reg;
   logic                wr_sel_next;
   logic                op_sel_next;

   assign wr_sel_next = spctl_wr ? CMD.op[`DQVR_WR_SEL_BIT] : wr_sel_reg;
   assign op_sel_next = spctl_wr ? CMD.op[`DQVR_OP_SEL_BIT] : op_sel_reg;

   always_ff @(posedge CMD_CLK or posedge lrst_reg) begin
      if (lrst_reg) begin
         wr_sel_reg <= `DQVR_SEL_RST;
         op_sel_reg <= `DQVR_SEL_RST;
      end else begin
         wr_sel_reg <= wr_sel_next;
         op_sel_reg <= op_sel_next;
      end
   end

   // two physical copies, one per set point
   logic [1:0]          copy_we;
   dqvr_level_t         copy_q [2];

   for (genvar i = 0; i < 2; i++) begin : g_copy
      // only the copy named by the write select takes the write
      assign copy_we[i] = level_wr & (wr_sel_reg == 1'(i));

      dqvr_sp_copy u_copy (
         .clk   (CMD_CLK),
         .rst   (lrst_reg),
         .we    (copy_we[i]),
         .wdata (wr_level),
         .level (copy_q[i])
      );
   end

   // mode register read: the write-selected copy goes out, bit for bit
   wire dqvr_level_t    rd_level;
   logic [7:0]          dq_reg;
   logic [7:0]          dq_next;
   logic                dq_oe_reg;
   logic                dq_oe_next;

   assign rd_level   = copy_q[wr_sel_reg];
   assign dq_next    = level_rd ? {1'h0, rd_level} : 8'h00;
   assign dq_oe_next = level_rd;

   always_ff @(posedge CMD_CLK or posedge lrst_reg) begin
      if (lrst_reg) begin
         dq_reg    <= 8'h00;
         dq_oe_reg <= 1'h0;
      end else begin
         dq_reg    <= dq_next;
         dq_oe_reg <= dq_oe_next;
      end
   end

   assign DQ_OUT = dq_reg;
   assign DQ_OE  = dq_oe_reg;

   // operating copy; the other copy is not looked at here at all
   dqvr_active_t        active_word;

   assign active_word.set_point = op_sel_reg;
   assign active_word.level     = copy_q[op_sel_reg];

   // ---------------- crossing to the core domain ----------------
   // two-phase style toggle handshake: the snapshot is held still until the
   // core has acknowledged it, so every bit is stable when it is captured.
   // a change that happens while a transfer is in flight is sent afterwards.
   dqvr_active_t        snap_reg;
   dqvr_active_t        snap_next;
   logic                req_reg;
   logic                req_next;
   logic                ack_meta_reg;
   logic                ack_sync_reg;
   logic                ack_reg;
   wire                 link_idle;
   wire                 snap_load;

   assign link_idle = (req_reg == ack_sync_reg);
   assign snap_load = link_idle & (active_word != snap_reg);
   assign snap_next = snap_load ? active_word : snap_reg;
   assign req_next  = snap_load ? ~req_reg : req_reg;

   always_ff @(posedge CMD_CLK or posedge lrst_reg) begin
      if (lrst_reg) begin
         snap_reg     <= '{set_point: `DQVR_SEL_RST,
                           level: '{range_sel: `DQVR_RANGE_RST, setting: `DQVR_SETTING_RST}};
         req_reg      <= 1'h0;
         ack_meta_reg <= 1'h0;
         ack_sync_reg <= 1'h0;
      end else begin
         snap_reg     <= snap_next;
         req_reg      <= req_next;
         ack_meta_reg <= ack_reg;
         ack_sync_reg <= ack_meta_reg;
      end
   end

   // ---------------- core domain ----------------
   // the reset pin is asynchronous to the core clock; its release passes two
   // flops so no core flop can leave reset on a metastable edge
   logic                crst_meta_reg;
   logic                crst_reg;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         crst_meta_reg <= 1'h1;
         crst_reg      <= 1'h1;
      end else begin
         crst_meta_reg <= 1'h0;
         crst_reg      <= crst_meta_reg;
      end
   end

   logic                req_meta_reg;
   logic                req_sync_reg;
   logic                ack_next;
   wire                 core_take;

   assign core_take = (req_sync_reg != ack_reg);
   assign ack_next  = core_take ? req_sync_reg : ack_reg;

   // active copy as seen by the core, plus its level as a fraction
   dqvr_level_t         act_level_reg;
   dqvr_level_t         act_level_next;
   logic                act_sp_reg;
   logic                act_sp_next;
   logic [9:0]          vref_reg;
   logic [9:0]          vref_next;
   wire  [9:0]          vref_base;
   wire  [9:0]          vref_step;
   wire  [5:0]          take_code;

   assign act_level_next = core_take ? snap_reg.level : act_level_reg;
   assign act_sp_next    = core_take ? snap_reg.set_point : act_sp_reg;

   // six tenths of a percent per code, from a base fixed by the range
   assign take_code = snap_reg.level.setting;
   assign vref_base = snap_reg.level.range_sel ? `DQVR_BASE_RANGE1 : `DQVR_BASE_RANGE0;
   assign vref_step = {2'h0, take_code, 2'h0} + {3'h0, take_code, 1'h0};
   assign vref_next = core_take ? (vref_base + vref_step) : vref_reg;

   always_ff @(posedge CORE_CLK or posedge crst_reg) begin
      if (crst_reg) begin
         req_meta_reg  <= 1'h0;
         req_sync_reg  <= 1'h0;
         ack_reg       <= 1'h0;
      end else begin
         req_meta_reg  <= req_reg;
         req_sync_reg  <= req_meta_reg;
         ack_reg       <= ack_next;
      end
   end

   always_ff @(posedge CORE_CLK or posedge crst_reg) begin
      if (crst_reg) begin
         act_level_reg <= '{range_sel: `DQVR_RANGE_RST, setting: `DQVR_SETTING_RST};
         act_sp_reg    <= `DQVR_SEL_RST;
         vref_reg      <= `DQVR_BASE_RANGE1;
      end else begin
         act_level_reg <= act_level_next;
         act_sp_reg    <= act_sp_next;
         vref_reg      <= vref_next;
      end
   end

   assign ACTIVE_LEVEL       = act_level_reg;
   assign ACTIVE_SET_POINT   = act_sp_reg;
   assign ACTIVE_VREF_TENTHS = vref_reg;

endmodule

//--- design/dqvr_sp_copy.sv
// one set-point copy of the reference setting and range
`timescale 1ns/1ns
`include "dqvr_defs.svh"

module dqvr_sp_copy (
   // clock and reset of the link domain
   input  wire logic               clk,
   input  wire logic               rst,
   // write port
   input  wire logic               we,
   input  wire dqvr_pkg::dqvr_level_t wdata,
   // stored value
   output dqvr_pkg::dqvr_level_t   level
);
   import dqvr_pkg::*;

   dqvr_level_t level_reg;
   dqvr_level_t level_next;

   // a copy only moves on its own enable; the other copy never sees this write
   assign level_next = we ? wdata : level_reg;
   assign level      = level_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_reg <= '{range_sel: `DQVR_RANGE_RST, setting: `DQVR_SETTING_RST};
      end else begin
         level_reg <= level_next;
      end
   end

endmodule

//--- pkg/dqvr_defs.svh
// offsets, field positions, reset values and limits of the dq reference mode register
`ifndef DQVR_DEFS_SVH
`define DQVR_DEFS_SVH

// mode register addresses on the command bus
`define DQVR_ADDR_LEVEL      6'h0e
`define DQVR_ADDR_SPCTL      6'h0d

// field positions inside the operand byte
`define DQVR_SETTING_MSB     5
`define DQVR_SETTING_LSB     0
`define DQVR_RANGE_BIT       6
`define DQVR_RESERVED_BIT    7
`define DQVR_WR_SEL_BIT      6
`define DQVR_OP_SEL_BIT      7

// reset values: range one, setting code zero, both selects on set point zero
`define DQVR_RANGE_RST       1'h1
`define DQVR_SETTING_RST     6'h00
`define DQVR_SEL_RST         1'h0

// highest legal setting code
`define DQVR_CODE_MAX        6'h32

// reference level in tenths of a percent of the output supply
`define DQVR_BASE_RANGE0     10'h096
`define DQVR_BASE_RANGE1     10'h149

`endif

//--- pkg/dqvr_pkg.sv
// types shared by the dq reference mode register design
package dqvr_pkg;

   // one set-point copy of the register contents
   typedef struct packed {
      logic       range_sel;
      logic [5:0] setting;
   } dqvr_level_t;

   // one command on the command/address bus, sampled on the link clock
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] op;
   } dqvr_cmd_t;

   // word carried from the link domain into the core domain
   typedef struct packed {
      logic        set_point;
      dqvr_level_t level;
   } dqvr_active_t;

endpackage
